//--- core/adc_compare_diag_control.sv
// ADC comparison diagnostic launch control with fault injection and interrupt status
// Summary of operation
// - Writing one to the start bit launches the diagnostic named by the three-bit selection field.
// - The selection is captured only on a start write of one; later field changes wait for the next start.
// - Reading the start bit returns it and then clears it to zero.
// - Writing zero to the start bit is ignored and the bit keeps its value.
// - While the comparison fault-inject enable is set, every comparison diagnostic reports a fail.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "diag_defines.svh"
module adc_compare_diag_control (
   input  wire logic               core_clk,
   input  wire logic               srst,
   input  wire logic [9:0]         addr,
   input  wire logic [7:0]         wdata,
   input  wire logic               wr_stb,
   input  wire logic               rd_stb,
   input  wire logic               compare_ok,
   input  wire logic               filter_ok,
   output logic [7:0]              rdata,
   output logic                    diag_busy,
   output logic [2:0]              diag_sel,
   output logic                    irq
);
   ////////////////////////////////////////////////////////////////////////////
   // register map seen by software; offsets and field positions sit in the defines header
   //   control three : bit 0 start (a one launches, a read clears), bits 3:1 selection
   //   control four  : bit 4 compare fault inject, bit 3 filter fault inject, other bits read zero
   //   irq status    : bit 0 done, bit 1 compare fail, bit 2 filter fail; read only and sticky
   //   irq enable    : same layout as the status, read and write
   //   irq clear     : same layout, a one clears that status bit, reads zero
   //   diag result   : bit 5 filter fail, bit 4 compare fail, bits 3:1 selection, bit 0 active
   // a start written during a run moves the captured selection only; the run keeps its own
   // selection zero sets the start bit but launches nothing
   // everything runs on the one core clock, so nothing crosses a clock domain
   // bus request and control register state
   diag_pkg::bus_req_s     req;
   logic [2:0]             sel_field_reg, sel_field_next;
   logic                   start_reg, start_next;
   logic [2:0]             sel_cap_reg, sel_cap_next;
   logic [7:0]             ctrl4_reg, ctrl4_next;
   // sequencer state
   diag_pkg::diag_state_e  state_reg, state_next;
   logic [3:0]             cnt_reg, cnt_next;
   diag_pkg::diag_status_s res_reg, res_next;
   // interrupt state
   logic [2:0]             stat_reg, stat_next;
   logic [2:0]             en_reg, en_next;
   // read path and event decode
   logic [7:0]             rdata_reg, rdata_next;
   logic [2:0]             ev;
   logic                   launch;

   // decode of a register write
   // used for each writable offset, so the address compare is written once
   function automatic logic hit(input diag_pkg::bus_req_s r, input logic [9:0] off);
      hit = r.wr && (r.addr == off);
   endfunction

   assign req    = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
   // launch needs a one in the start bit; a zero write only moves the selection field
   assign launch = hit(req, `OFF_COMP_CTRL3) && wdata[`BIT_START];

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   // defaults hold every register
   always_comb begin
      sel_field_next = sel_field_reg;
      start_next     = start_reg;
      sel_cap_next   = sel_cap_reg;
      ctrl4_next     = ctrl4_reg;
      // a field write moves the visible selection whether or not it starts
      if (hit(req, `OFF_COMP_CTRL3)) begin
         sel_field_next = wdata[`POS_SEL_HI:`POS_SEL_LO];
      end
      if (launch) begin
         start_next   = 1'b1;
         sel_cap_next = wdata[`POS_SEL_HI:`POS_SEL_LO];
      end
      // a zero start write leaves the start bit alone
      // a read clears the start bit; a start in the same cycle keeps it
      if (rd_stb && addr == `OFF_COMP_CTRL3 && !launch) begin
         start_next = 1'b0;
      end
      if (hit(req, `OFF_COMP_CTRL4)) begin
         ctrl4_next = wdata & `CTRL4_MASK;
      end
   end

   // control register flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sel_field_reg <= 3'h0;
         start_reg     <= 1'b0;
         sel_cap_reg   <= 3'h0;
         ctrl4_reg     <= `RST_CTRL4;
      end else begin
         sel_field_reg <= sel_field_next;
         start_reg     <= start_next;
         sel_cap_reg   <= sel_cap_next;
         ctrl4_reg     <= ctrl4_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // diagnostic run sequencer
   // defaults hold state, count and result and raise no event
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      res_next   = res_reg;
      ev         = 3'h0;
      case (state_reg)
         diag_pkg::ST_IDLE: begin
            // a start with a real selection opens a run
            if (launch && wdata[`POS_SEL_HI:`POS_SEL_LO] != `SEL_NONE) begin
               state_next    = diag_pkg::ST_RUN;
               cnt_next      = `RUN_CYCLES;
               res_next.active = 1'b1;
               res_next.sel    = wdata[`POS_SEL_HI:`POS_SEL_LO];
            end
         end
         diag_pkg::ST_RUN: begin
            // count the run down; the last count moves to done
            // inject enables are read at done, so a change during the run still counts
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) begin
               state_next = diag_pkg::ST_DONE;
            end
         end
         diag_pkg::ST_DONE: begin
            // pass inputs are sampled once here and must be settled by then
            // apply the inject enables and raise the events
            res_next.active    = 1'b0;
            res_next.comp_fail = !compare_ok || ctrl4_reg[`POS_COMP_INJ];
            res_next.filter_fail_flag = (res_reg.sel == `SEL_FILTER) &&
               (!filter_ok || ctrl4_reg[`POS_FILT_INJ]);
            ev[`EV_DONE]      = 1'b1;
            ev[`EV_COMP_FAIL] = !compare_ok || ctrl4_reg[`POS_COMP_INJ];
            ev[`EV_FILT_FAIL] = res_next.filter_fail_flag;
            state_next = diag_pkg::ST_IDLE;
         end
         default: begin
            // an unused encoding falls back to idle
            state_next = diag_pkg::ST_IDLE;
         end
      endcase
   end

   // sequencer flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= diag_pkg::ST_IDLE;
         cnt_reg   <= 4'h0;
         res_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         res_reg   <= res_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, enable and clear; a new event wins over a clear
   // status and result offsets are read only; writes to them fall through
   always_comb begin
      stat_next = stat_reg;
      en_next   = en_reg;
      if (hit(req, `OFF_IRQ_CLEAR)) begin
         stat_next = stat_reg & ~wdata[2:0];
      end
      // clear first, then or in the new events so a set in the same cycle wins
      stat_next = stat_next | ev;
      // enable is a plain read and write register
      if (hit(req, `OFF_IRQ_ENABLE)) begin
         en_next = wdata[2:0];
      end
   end

   // interrupt flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         stat_reg <= 3'h0;
         en_reg   <= 3'h0;
      end else begin
         stat_reg <= stat_next;
         en_reg   <= en_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, valid in the cycle after the read strobe
   always_comb begin
      rdata_next = 8'h00;
      // only a read strobe opens the mux; zero otherwise
      if (rd_stb) begin
         // write-only and unmapped offsets read as zero
         case (addr)
            `OFF_COMP_CTRL3:  rdata_next = {4'h0, sel_field_reg, start_reg};
            `OFF_COMP_CTRL4:  rdata_next = ctrl4_reg;
            `OFF_IRQ_STATUS:  rdata_next = {5'h00, stat_reg};
            `OFF_IRQ_ENABLE:  rdata_next = {5'h00, en_reg};
            `OFF_DIAG_RESULT: rdata_next = {2'h0, res_reg.filter_fail_flag, res_reg.comp_fail,
                                            res_reg.sel, res_reg.active};
            default:          rdata_next = 8'h00;
         endcase
      end
   end

   // read data flop; zero outside the answer cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops; irq is a level from status and enable
   assign rdata     = rdata_reg;
   assign diag_busy = res_reg.active;
   assign diag_sel  = sel_cap_reg;
   assign irq       = |(stat_reg & en_reg);
endmodule

//--- core/diag_defines.svh
// offsets, field positions, reset values and timing counts for the diagnostic control block
`ifndef DIAG_DEFINES_SVH
`define DIAG_DEFINES_SVH
`define ADDR_W              10
`define OFF_COMP_CTRL3      10'h33C
`define OFF_COMP_CTRL4      10'h33D
`define OFF_IRQ_STATUS      10'h340
`define OFF_IRQ_ENABLE      10'h341
`define OFF_IRQ_CLEAR       10'h342
`define OFF_DIAG_RESULT     10'h343
`define BIT_START           0
`define POS_SEL_LO          1
`define POS_SEL_HI          3
`define POS_FILT_INJ        3
`define POS_COMP_INJ        4
`define RST_CTRL3           8'h00
`define RST_CTRL4           8'h00
`define CTRL4_MASK          8'h18
`define RUN_CYCLES          4'h8
`define SEL_NONE            3'h0
`define SEL_FILTER          3'h5
`define EV_DONE             0
`define EV_COMP_FAIL        1
`define EV_FILT_FAIL        2
`endif

//--- core/diag_pkg.sv
// types for the diagnostic control block
package diag_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} diag_state_e;
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_s;
   typedef struct packed {
      logic       active;
      logic [2:0] sel;
      logic       comp_fail;
      logic       filter_fail_flag;
   } diag_status_s;
endpackage

//--- testbench/adc_compare_diag_control_properties.sv
// port-level checks for the diagnostic launch control
`timescale 1ns/1ps
`include "diag_defines.svh"
module adc_compare_diag_control_properties (
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rdata,
   input wire logic       diag_busy,
   input wire logic [2:0] diag_sel
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // start write and control read decodes
   wire logic go = wr_stb && addr == `OFF_COMP_CTRL3 && wdata[0];
   wire logic rd3 = rd_stb && addr == `OFF_COMP_CTRL3;
   ////////////////////////////////////////
   AST_START_RUNS: assert property (go && wdata[3:1] != `SEL_NONE && !diag_busy |=> diag_busy)
      else $error("start write did not launch");
   AST_RUN_ENDS: assert property ($rose(diag_busy) |-> ##[8:16] !diag_busy)
      else $error("diagnostic never finished");
   AST_SEL_CAPTURE: assert property (go |=> diag_sel == $past(wdata[3:1]))
      else $error("selection not captured");
   AST_SEL_HOLD: assert property (!go |=> $stable(diag_sel))
      else $error("selection moved without start");
   AST_READ_CLEARS: assert property (rd3 ##1 rd3 |=> !rdata[0])
      else $error("start bit survived a read");
   AST_RDATA_IDLE: assert property (!rd_stb |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   AST_ZERO_IGNORED: assert property (wr_stb && addr == `OFF_COMP_CTRL3 && !wdata[0] && !diag_busy |=> !diag_busy)
      else $error("zero write launched");
   // main scenario coverage
   cover property (go);
   cover property ($fell(diag_busy));
   cover property (rd3 ##1 rd3);
endmodule

//--- testbench/adc_compare_diag_control_tb.sv
// self-checking bench for the diagnostic launch control
`timescale 1ns/1ps
`include "diag_defines.svh"
module adc_compare_diag_control_tb;
   logic       core_clk = 1'b0;
   logic       srst = 1'b1;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic       wr_stb = 1'b0;
   logic       rd_stb = 1'b0;
   logic       compare_ok = 1'b1;
   logic       filter_ok = 1'b1;
   logic [7:0] rdata;
   logic       diag_busy;
   logic [2:0] diag_sel;
   logic       irq;
   int         failures = 0;
   int         check_count = 0;
   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;
   adc_compare_diag_control i_adc_compare_diag_control (.core_clk(core_clk), .srst(srst), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .compare_ok(compare_ok), .filter_ok(filter_ok),
      .rdata(rdata), .diag_busy(diag_busy), .diag_sel(diag_sel), .irq(irq));
   ////////////////////////////////////////
   // compare, bus cycles and run helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rc(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 chk(rdata & m, e);
   endtask
   // two reads of one offset back to back, strobe held across both
   task automatic rc2(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e1, input logic [7:0] e2);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      #1 chk(rdata & m, e1);
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 chk(rdata & m, e2);
   endtask
   task automatic go(input logic [2:0] s);
      wr(`OFF_COMP_CTRL3, {4'h0, s, 1'b1});
      chk({7'h00, diag_busy}, 8'h01);
      chk({5'h00, diag_sel}, {5'h00, s});
   endtask
   task automatic fin;
      for (int n = 0; n < 40 && diag_busy !== 1'b0; n++) @(posedge core_clk) #1;
      chk({7'h00, diag_busy}, 8'h00);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      #20000;
      failures++;
      wrap_up();
   end
   // test sequence
   initial begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      rc(`OFF_COMP_CTRL4, 8'hFF, `RST_CTRL4);
      rc(`OFF_COMP_CTRL3, 8'hFF, `RST_CTRL3);
      rc(10'h000, 8'hFF, 8'h00);
      wr(`OFF_COMP_CTRL3, 8'h0A);
      chk({7'h00, diag_busy}, 8'h00);
      chk({5'h00, diag_sel}, 8'h00);
      rc(`OFF_COMP_CTRL3, 8'h01, 8'h00);
      $display("test reset and zero write done");
      wr(`OFF_IRQ_ENABLE, 8'h07);
      go(3'h3);
      wr(`OFF_COMP_CTRL3, 8'h0C);
      chk({5'h00, diag_sel}, 8'h03);
      rc(`OFF_COMP_CTRL3, 8'h01, 8'h01);
      rc(`OFF_COMP_CTRL3, 8'h01, 8'h00);
      fin();
      rc(`OFF_IRQ_STATUS, 8'h07, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(`OFF_IRQ_CLEAR, 8'h07);
      chk({7'h00, irq}, 8'h00);
      $display("test launch done");
      wr(`OFF_COMP_CTRL4, 8'hFF);
      rc(`OFF_COMP_CTRL4, 8'hFF, `CTRL4_MASK);
      go(3'h1);
      rc2(`OFF_COMP_CTRL3, 8'h01, 8'h01, 8'h00);
      fin();
      rc(`OFF_IRQ_STATUS, 8'h07, 8'h03);
      wr(`OFF_COMP_CTRL4, 8'h08);
      wr(`OFF_IRQ_CLEAR, 8'h07);
      go(`SEL_FILTER);
      fin();
      rc(`OFF_IRQ_STATUS, 8'h07, 8'h05);
      rc(`OFF_DIAG_RESULT, 8'h20, 8'h20);
      wr(`OFF_IRQ_ENABLE, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wr(`OFF_IRQ_STATUS, 8'h00);
      rc(`OFF_IRQ_STATUS, 8'h07, 8'h05);
      $display("test fault inject done");
      wr(`OFF_COMP_CTRL4, 8'h00);
      wr(`OFF_IRQ_CLEAR, 8'h07);
      @(posedge core_clk);
      compare_ok <= 1'b0;
      filter_ok <= 1'b0;
      go(`SEL_FILTER);
      fin();
      rc(`OFF_IRQ_STATUS, 8'h07, 8'h07);
      $display("test real fail done");
      go(3'h2);
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      chk({7'h00, diag_busy}, 8'h00);
      chk({5'h00, diag_sel}, 8'h00);
      chk({7'h00, irq}, 8'h00);
      rc(`OFF_IRQ_STATUS, 8'h07, 8'h00);
      rc(`OFF_COMP_CTRL3, 8'hFF, `RST_CTRL3);
      $display("test reset mid run done");
      wrap_up();
   end
endmodule
bind adc_compare_diag_control adc_compare_diag_control_properties i_adc_compare_diag_control_properties (
   .core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rdata(rdata), .diag_busy(diag_busy), .diag_sel(diag_sel));
